/* common/cmb_consts.svh */
// Constants for the CAN message buffering block: offsets, fields, reset values
`ifndef CMB_CONSTS_SVH
`define CMB_CONSTS_SVH

// ==========================================================================
// Message buffer geometry
`define CMB_BUF_BYTES      4'hd
`define CMB_LOCAL_PRIORITY_FIELD_IDX       4'hd
`define CMB_NUM_TX         3

// ==========================================================================
// Register map: addr[7:4] selects a page, addr[3:0] the byte within it
`define CMB_FG_PAGE        4'h0
`define CMB_TX_PAGE0       4'h1
`define CMB_TX_PAGE2       4'h3
`define CMB_CTL_PAGE       4'h4
`define CMB_RFLG_OFS       4'h0
`define CMB_RIER_OFS       4'h1
`define CMB_TFLG_OFS       4'h2
`define CMB_TCR_OFS        4'h3
`define CMB_MCR1_OFS       4'h4

// ==========================================================================
// Field positions
`define CMB_RFLG_RXF       0
`define CMB_RFLG_OVR       1
`define CMB_RIER_RXIE      0
`define CMB_RIER_OVRIE     1
`define CMB_TFLG_ABORT_ACKNOWLEDGE_FLAG_LSB 4
`define CMB_TCR_TXEIE_LSB  4
`define CMB_MCR1_LOOPB     0

// ==========================================================================
// Reset values and pin levels
`define CMB_TXE_RST        3'h7
`define CMB_PIN_RECESSIVE  1'b1
`define CMB_RDATA_NONE     8'h00

`endif

/* common/cmb_pkg.sv */
// Types shared by the CAN message buffering block
`default_nettype none

package cmb_pkg;

  typedef logic [7:0]       cmb_byte_t;
  typedef logic [12:0][7:0] cmb_buf_t;

  typedef enum logic {
    CMB_TX_IDLE,
    CMB_TX_BUSY
  } cmb_tx_e;

  typedef struct packed {
    cmb_buf_t            bg;
    cmb_buf_t            fg;
    logic                bg_full;
    logic                rx_full;
    logic                ovr;
    logic                rx_ie;
    logic                ovr_ie;
    logic [2:0]          tx_buffer_empty_flag;
    logic [2:0]          abort_acknowledge_flag;
    logic [2:0]          abort_request_flag;
    logic [2:0]          txeie;
    logic                loopback;
    cmb_buf_t [2:0]      txb;
    logic [2:0][7:0]     local_priority_field;
    cmb_tx_e             txst;
    logic [1:0]          sel;
    cmb_byte_t           rdata;
    cmb_byte_t           tx_byte;
    logic                tx_req;
    logic                tx_pin;
    logic                rx_bit;
    logic                rx_irq;
    logic                err_irq;
    logic                tx_irq;
  } cmb_state_s;

endpackage : cmb_pkg

`default_nettype wire

/* design/cmb_tx_pick.sv */
// Transmit buffer selector: lowest local priority value among scheduled buffers
`default_nettype none

module cmb_tx_pick (
  input  wire logic [2:0]      sched,
  input  wire logic [2:0][7:0] local_priority_field,
  output logic      [1:0]      sel,
  output logic                 any
);
  import cmb_pkg::*;

  logic [7:0] best;

  always_comb begin
    sel  = 2'h0;
    any  = 1'b0;
    best = 8'hff;
    for (int i = 0; i < 3; i++) begin
      // Strict compare keeps the lower index on equal priority [R24]
      if (sched[i] && (!any || local_priority_field[i] < best)) begin  // [R19]
        any  = 1'b1;
        sel  = 2'(i);
        best = local_priority_field[i];
      end
    end
  end

endmodule // cmb_tx_pick

`default_nettype wire

/* design/cmb_msg_buf.sv */
// CAN message buffering: two-stage receive FIFO, three prioritised transmit buffers
//
// Overview of operation
// (R1) Exactly two bus pins: one receive input, one transmit output.
// (R2) Transmit pin drives 0 for dominant and 1 for recessive.
// (R3) Receive path is background buffer plus one CPU-visible foreground buffer.
// (R4) Each receive buffer holds 13 bytes: control, identifier and data.
// (R5) rx_full_flag set when foreground holds a correct accepted frame.
// (R6) Filter result is taken alongside the bytes written into background.
// (R7) Copy background to foreground only while rx_full_flag clear, then set it.
// (R8) Receive interrupt only when unmasked; otherwise software polls the flag.
// (R9) Software reads foreground, then clears rx_full_flag to free it.
// (R10) Every incoming frame overwrites background, accepted or not; here not while background holds a pending frame.
// (R11) Own transmitted frame goes to background only; no foreground, irq or ack.
// (R12) Loop-back mode treats own frames like any other incoming frame.
// (R13) Lost arbitration turns the controller into a receiver of the winner.
// (R14) Accepted frame with both buffers full is discarded and overrun flagged.
// (R15) With both buffers full, transmission continues and incoming frames drop.
// (R16) Three transmit buffers of 13 bytes, each with an 8-bit priority.
// (R17) Software loads an empty buffer, then clears its empty flag to schedule.
// (R18) Successful send sets the empty flag and a transmit irq if unmasked.
// (R19) Lowest priority value among scheduled buffers is sent first.
// (R20) Buffer selection reruns at every arbitration, also after errors.
// (R21) Abort request on an idle buffer sets acknowledge and empty flags.
// (R22) Acknowledge reads 1 when aborted, 0 when the frame was sent.
// (R23) Flags clear by writing one; a flag stays while its cause persists.
// (R24) Equal priorities pick the lowest-numbered buffer.
//
// Local design decisions: the register offsets and the strobed register port.
`include "cmb_consts.svh"
`default_nettype none

module cmb_msg_buf (
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // Register port
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [7:0]       reg_rdata,
  // Bus pins
  input  wire logic             bus_receive_pin,
  output logic                  bus_transmit_pin,
  // Protocol engine, receive side
  output logic                  eng_rx_bit,
  input  wire logic             eng_rx_byte_valid,
  input  wire logic [3:0]       eng_rx_byte_index,
  input  wire cmb_pkg::cmb_byte_t eng_rx_byte,
  input  wire logic             eng_rx_frame_ok,
  input  wire logic             eng_rx_accept,
  // Protocol engine, transmit side
  input  wire logic             eng_tx_bit,
  output logic                  eng_tx_req,
  input  wire logic             eng_arb_start,
  output logic      [1:0]       eng_tx_sel,
  output logic                  eng_tx_active,
  input  wire logic [3:0]       eng_tx_byte_index,
  output cmb_pkg::cmb_byte_t    eng_tx_byte,
  input  wire logic             eng_tx_done,
  input  wire logic             eng_tx_fail,
  // Interrupt requests
  output logic                  rx_irq,
  output logic                  err_irq,
  output logic                  tx_irq
);
  import cmb_pkg::*;

  // ========================================================================
  // State
  cmb_state_s s_q;
  cmb_state_s s_d;

  logic [2:0] sched;
  logic [1:0] pick_sel;
  logic       pick_any;
  logic [3:0] page;
  logic [3:0] ofs;
  logic [1:0] wbuf;
  logic       own_frame;

  assign sched     = ~s_q.tx_buffer_empty_flag;
  assign page      = reg_addr[7:4];
  assign ofs       = reg_addr[3:0];
  assign wbuf      = 2'(page - `CMB_TX_PAGE0);
  // Own frames skip the foreground unless looped back [R11] [R12]
  assign own_frame = (s_q.txst == CMB_TX_BUSY) && !s_q.loopback;

  cmb_tx_pick u_pick (
    .sched (sched),
    .local_priority_field  (s_q.local_priority_field),
    .sel   (pick_sel),
    .any   (pick_any)
  );

  // ========================================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // ----- Register writes -----
    if (reg_wr) begin
      if (page >= `CMB_TX_PAGE0 && page <= `CMB_TX_PAGE2) begin
        // A scheduled buffer belongs to the controller; writes are dropped
        if (s_q.tx_buffer_empty_flag[wbuf]) begin  // [R17]
          if (ofs < `CMB_BUF_BYTES) begin
            s_d.txb[wbuf][ofs] = reg_wdata;  // [R16]
          end else if (ofs == `CMB_LOCAL_PRIORITY_FIELD_IDX) begin
            s_d.local_priority_field[wbuf] = reg_wdata;  // [R16]
          end
        end
      end else if (page == `CMB_CTL_PAGE) begin
        unique case (ofs)
          `CMB_RFLG_OFS: begin
            if (reg_wdata[`CMB_RFLG_RXF]) begin
              s_d.rx_full = 1'b0;  // [R9] [R23]
            end
            // Overrun holds while both buffers stay occupied [R23]
            if (reg_wdata[`CMB_RFLG_OVR] && !(s_q.bg_full && s_q.rx_full)) begin
              s_d.ovr = 1'b0;
            end
          end
          `CMB_RIER_OFS: begin
            s_d.rx_ie  = reg_wdata[`CMB_RIER_RXIE];
            s_d.ovr_ie = reg_wdata[`CMB_RIER_OVRIE];
          end
          `CMB_TFLG_OFS: begin
            // Clearing an empty flag schedules the buffer [R17] [R23]
            for (int i = 0; i < 3; i++) begin
              if (reg_wdata[i] && s_q.tx_buffer_empty_flag[i]) begin
                s_d.tx_buffer_empty_flag[i]   = 1'b0;
                s_d.abort_acknowledge_flag[i] = 1'b0;
              end
            end
          end
          `CMB_TCR_OFS: begin
            for (int i = 0; i < 3; i++) begin
              if (reg_wdata[i] && !s_q.tx_buffer_empty_flag[i]) begin
                s_d.abort_request_flag[i] = 1'b1;  // [R21]
              end
            end
            s_d.txeie = reg_wdata[`CMB_TCR_TXEIE_LSB +: 3];
          end
          `CMB_MCR1_OFS: begin
            s_d.loopback = reg_wdata[`CMB_MCR1_LOOPB];
          end
          default: begin
          end
        endcase
      end
    end

    // ----- Receive path -----
    // Bytes land in the background while the filter runs [R6] [R10]
    // A held background is protected so a pending frame is not corrupted [R15]
    if (eng_rx_byte_valid && !s_q.bg_full && eng_rx_byte_index < `CMB_BUF_BYTES) begin
      s_d.bg[eng_rx_byte_index] = eng_rx_byte;  // [R3] [R4]
    end

    // Foreground freed while a frame waits: move it up [R7]
    if (s_q.bg_full && !s_d.rx_full) begin
      s_d.fg      = s_q.bg;
      s_d.rx_full = 1'b1;
      s_d.bg_full = 1'b0;
    end

    if (eng_rx_frame_ok && !own_frame && eng_rx_accept) begin
      if (s_q.bg_full) begin
        s_d.ovr = 1'b1;  // [R14] [R15]
      end else if (!s_d.rx_full) begin
        s_d.fg      = s_q.bg;  // [R7]
        s_d.rx_full = 1'b1;  // [R5]
      end else begin
        s_d.bg_full = 1'b1;  // [R3]
      end
    end

    // ----- Transmit scheduling -----
    unique case (s_q.txst)
      CMB_TX_IDLE: begin
        // Selection is made afresh at every arbitration attempt [R20]
        if (eng_arb_start && pick_any) begin
          s_d.txst = CMB_TX_BUSY;
          s_d.sel  = pick_sel;  // [R19] [R24]
        end
      end
      CMB_TX_BUSY: begin
        if (eng_tx_done) begin
          s_d.tx_buffer_empty_flag[s_q.sel]   = 1'b1;  // [R18]
          s_d.abort_acknowledge_flag[s_q.sel] = 1'b0;  // [R22]
          s_d.abort_request_flag[s_q.sel] = 1'b0;
          s_d.txst           = CMB_TX_IDLE;
        end else if (eng_tx_fail) begin
          // Error or lost arbitration: stay scheduled, become receiver [R13] [R20]
          s_d.txst = CMB_TX_IDLE;
        end
      end
    endcase

    // Abort is granted only for a buffer not on the bus [R21]
    for (int i = 0; i < 3; i++) begin
      if (s_q.abort_request_flag[i] && !s_q.tx_buffer_empty_flag[i] &&
          !(s_q.txst == CMB_TX_BUSY && s_q.sel == 2'(i))) begin
        s_d.tx_buffer_empty_flag[i]   = 1'b1;  // [R21]
        s_d.abort_acknowledge_flag[i] = 1'b1;  // [R22]
        s_d.abort_request_flag[i] = 1'b0;
      end
    end

    // ----- Register reads, answered one cycle later -----
    s_d.rdata = `CMB_RDATA_NONE;
    if (reg_rd) begin
      if (page == `CMB_FG_PAGE) begin
        if (ofs < `CMB_BUF_BYTES) begin
          s_d.rdata = s_q.fg[ofs];  // [R3]
        end
      end else if (page >= `CMB_TX_PAGE0 && page <= `CMB_TX_PAGE2) begin
        if (ofs < `CMB_BUF_BYTES) begin
          s_d.rdata = s_q.txb[wbuf][ofs];
        end else if (ofs == `CMB_LOCAL_PRIORITY_FIELD_IDX) begin
          s_d.rdata = s_q.local_priority_field[wbuf];
        end
      end else if (page == `CMB_CTL_PAGE) begin
        unique case (ofs)
          `CMB_RFLG_OFS: begin
            s_d.rdata[`CMB_RFLG_RXF] = s_q.rx_full;
            s_d.rdata[`CMB_RFLG_OVR] = s_q.ovr;
          end
          `CMB_RIER_OFS: begin
            s_d.rdata[`CMB_RIER_RXIE]  = s_q.rx_ie;
            s_d.rdata[`CMB_RIER_OVRIE] = s_q.ovr_ie;
          end
          `CMB_TFLG_OFS: begin
            s_d.rdata[2:0]                      = s_q.tx_buffer_empty_flag;
            s_d.rdata[`CMB_TFLG_ABORT_ACKNOWLEDGE_FLAG_LSB +: 3] = s_q.abort_acknowledge_flag;
          end
          `CMB_TCR_OFS: begin
            s_d.rdata[2:0]                     = s_q.abort_request_flag;
            s_d.rdata[`CMB_TCR_TXEIE_LSB +: 3] = s_q.txeie;
          end
          `CMB_MCR1_OFS: begin
            s_d.rdata[`CMB_MCR1_LOOPB] = s_q.loopback;
          end
          default: begin
          end
        endcase
      end
    end

    // ----- Engine data and pins -----
    s_d.tx_byte = (eng_tx_byte_index < `CMB_BUF_BYTES) ?
                  s_q.txb[s_q.sel][eng_tx_byte_index] : `CMB_RDATA_NONE;
    s_d.tx_req  = |sched;
    // Loop-back keeps the bus recessive and feeds the own bit back [R12]
    s_d.tx_pin  = s_q.loopback ? `CMB_PIN_RECESSIVE : eng_tx_bit;  // [R1] [R2]
    s_d.rx_bit  = s_q.loopback ? eng_tx_bit : bus_receive_pin;  // [R1]

    // ----- Interrupt requests follow flags and masks -----
    s_d.rx_irq  = s_d.rx_full & s_d.rx_ie;  // [R8]
    s_d.err_irq = s_d.ovr & s_d.ovr_ie;  // [R14]
    s_d.tx_irq  = |(s_d.tx_buffer_empty_flag & s_d.txeie);  // [R18] [R21]
  end

  // ========================================================================
  // State register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      s_q        <= '0;
      s_q.tx_buffer_empty_flag    <= `CMB_TXE_RST;
      s_q.tx_pin <= `CMB_PIN_RECESSIVE;
      s_q.rx_bit <= `CMB_PIN_RECESSIVE;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs
  assign reg_rdata        = s_q.rdata;
  assign bus_transmit_pin = s_q.tx_pin;
  assign eng_rx_bit       = s_q.rx_bit;
  assign eng_tx_req       = s_q.tx_req;
  assign eng_tx_sel       = s_q.sel;
  assign eng_tx_active    = (s_q.txst == CMB_TX_BUSY);
  assign eng_tx_byte      = s_q.tx_byte;
  assign rx_irq           = s_q.rx_irq;
  assign err_irq          = s_q.err_irq;
  assign tx_irq           = s_q.tx_irq;

endmodule // cmb_msg_buf

`default_nettype wire

/* tb/cmb_bus_model.sv */
// Bus model: transceiver plus other nodes on a wired-AND line
`default_nettype none

module cmb_bus_model (
  input  wire logic tx_pin,
  input  wire logic other_dom,
  output logic      rx_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Dominant wins: any node driving 0 pulls the line low
  assign rx_pin = tx_pin & ~other_dom;
endmodule  // cmb_bus_model

`default_nettype wire

/* tb/cmb_msg_buf_asserts.sv */
// Port checker for the CAN message buffering block
`default_nettype none

module cmb_msg_buf_asserts (
  input wire logic               ref_clk,
  input wire logic               rstn,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [7:0]         reg_rdata,
  input wire logic               bus_receive_pin,
  input wire logic               bus_transmit_pin,
  input wire logic               eng_rx_bit,
  input wire logic               eng_rx_frame_ok,
  input wire logic               eng_tx_bit,
  input wire logic               eng_tx_req,
  input wire logic               eng_arb_start,
  input wire logic [1:0]         eng_tx_sel,
  input wire logic               eng_tx_active,
  input wire logic [3:0]         eng_tx_byte_index,
  input wire cmb_pkg::cmb_byte_t eng_tx_byte,
  input wire logic               eng_tx_done,
  input wire logic               eng_tx_fail,
  input wire logic               rx_irq,
  input wire logic               err_irq,
  input wire logic               tx_irq
);
  timeunit 1ns;
  timeprecision 1ns;
  import cmb_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Pins, transmit handshake and interrupt causes
  property p_dom; !bus_transmit_pin |-> !$past(eng_tx_bit); endproperty
  a_dom: assert property (p_dom) else $error("dominant without engine");
  property p_rxb; !eng_rx_bit |-> !$past(bus_receive_pin) || !$past(eng_tx_bit); endproperty
  a_rxb: assert property (p_rxb) else $error("receive bit from nowhere");
  property p_arb; $rose(eng_tx_active) |-> $past(eng_arb_start) && $past(eng_tx_req); endproperty
  a_arb: assert property (p_arb) else $error("send without arbitration");
  property p_hold; eng_tx_active && !eng_tx_done && !eng_tx_fail
    |=> eng_tx_active && $stable(eng_tx_sel); endproperty
  a_hold: assert property (p_hold) else $error("selection moved mid frame");
  property p_rel; eng_tx_active && (eng_tx_done || eng_tx_fail) |=> !eng_tx_active; endproperty
  a_rel: assert property (p_rel) else $error("buffer not released");
  // Interrupts may only rise one or two cycles after their causes
  property p_tirq; $rose(tx_irq)
    |-> $past(eng_tx_done) || $past(reg_wr) || $past(reg_wr, 2) || $past(eng_tx_fail, 2);
  endproperty
  a_tirq: assert property (p_tirq) else $error("transmit irq without cause");
  property p_rirq; $rose(rx_irq)
    |-> $past(eng_rx_frame_ok) || $past(reg_wr); endproperty
  a_rirq: assert property (p_rirq) else $error("receive irq without cause");
  property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  a_rdz: assert property (p_rdz) else $error("read data outside slot");
  property p_tby; eng_tx_byte_index > 4'hc |=> eng_tx_byte == 8'h00; endproperty
  a_tby: assert property (p_tby) else $error("byte beyond buffer");
  c_tx: cover property ($rose(eng_tx_active));
  c_rx: cover property ($rose(rx_irq));
  c_ovr: cover property ($rose(err_irq));
endmodule  // cmb_msg_buf_asserts

`default_nettype wire

/* tb/tb_top.sv */
// Self-checking testbench for the CAN message buffering block
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import cmb_pkg::*;
  logic       ref_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       rxv = 1'b0, rok = 1'b0, racc = 1'b0, arb = 1'b0, done = 1'b0;
  logic       fail = 1'b0, etb = 1'b1, other_dom = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [3:0] rxi = 4'h0, txi = 4'hf;
  cmb_byte_t  rxb = 8'h00, txb;
  logic       txp, rxp, erb, treq, act, rirq, eirq, tirq;
  logic [1:0] sel;
  int         errors = 0, n_tests = 0;

  cmb_msg_buf u_cmb_msg_buf (
    .ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .bus_receive_pin(rxp), .bus_transmit_pin(txp), .eng_rx_bit(erb),
    .eng_rx_byte_valid(rxv), .eng_rx_byte_index(rxi), .eng_rx_byte(rxb),
    .eng_rx_frame_ok(rok), .eng_rx_accept(racc), .eng_tx_bit(etb),
    .eng_tx_req(treq), .eng_arb_start(arb), .eng_tx_sel(sel),
    .eng_tx_active(act), .eng_tx_byte_index(txi), .eng_tx_byte(txb),
    .eng_tx_done(done), .eng_tx_fail(fail), .rx_irq(rirq),
    .err_irq(eirq), .tx_irq(tirq)
  );
  cmb_bus_model u_cmb_bus_model (.tx_pin(txp), .other_dom, .rx_pin(rxp));

  always #50 ref_clk = ~ref_clk;

  // ==========================================================================
  // Bus and engine tasks; every task starts and ends just after an edge
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // The idle edge after the strobe keeps two writes from colliding
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
    @(posedge ref_clk);
  endtask
  task automatic frame(logic [7:0] base, logic acc);
    for (int i = 0; i < 13; i++) begin
      rxv <= 1'b1;
      rxi <= i[3:0];
      rxb <= base + i[7:0];
      @(posedge ref_clk);
    end
    rxv <= 1'b0;
    rok <= 1'b1;
    racc <= acc;
    @(posedge ref_clk);
    rok <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
  // Byte 5 of buffer k holds a0 plus k, so the fetch shows which buffer is on the bus
  task automatic go(logic [1:0] k, logic ok);
    arb <= 1'b1;
    txi <= 4'h5;
    @(posedge ref_clk);
    arb <= 1'b0;
    #1 chk({6'h0, sel}, {6'h0, k});
    chk({7'h0, act}, 8'h01);
    chk({7'h0, treq}, 8'h01);
    @(posedge ref_clk);
    done <= ok;
    fail <= ~ok;
    #1 chk(txb, 8'ha0 + {6'h0, k});
    @(posedge ref_clk);
    done <= 1'b0;
    fail <= 1'b0;
    txi <= 4'hf;
    @(posedge ref_clk);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_pins();
    rd(8'h42, 8'h07);
    rd(8'h77, 8'h00);
    etb <= 1'b0;
    other_dom <= 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 chk({7'h0, txp}, 8'h00);
    chk({7'h0, erb}, 8'h00);
    etb <= 1'b1;
    other_dom <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic t_rx();
    wr(8'h41, 8'h01);
    frame(8'h10, 1'b0);
    rd(8'h40, 8'h00);
    frame(8'h20, 1'b1);
    rd(8'h40, 8'h01);
    chk({7'h0, rirq}, 8'h01);
    rd(8'h00, 8'h20);
    rd(8'h0c, 8'h2c);
  endtask
  // Foreground holds 20, background 30; the frame at 40 must vanish
  task automatic t_ovr();
    frame(8'h30, 1'b1);
    frame(8'h40, 1'b1);
    wr(8'h41, 8'h03);
    wr(8'h40, 8'h02);
    rd(8'h40, 8'h03);
    chk({7'h0, eirq}, 8'h01);
    wr(8'h40, 8'h01);
    rd(8'h00, 8'h30);
    wr(8'h40, 8'h03);
    rd(8'h40, 8'h00);
    wr(8'h41, 8'h00);
  endtask
  task automatic t_local_priority_field();
    wr(8'h1d, 8'h05);
    wr(8'h2d, 8'h03);
    wr(8'h3d, 8'h03);
    wr(8'h15, 8'ha0);
    wr(8'h25, 8'ha1);
    wr(8'h35, 8'ha2);
    wr(8'h42, 8'h07);
    go(2'd1, 1'b0);
    go(2'd1, 1'b1);
    go(2'd2, 1'b1);
    go(2'd0, 1'b1);
    wr(8'h43, 8'h70);
    rd(8'h42, 8'h07);
    chk({7'h0, tirq}, 8'h01);
    chk({7'h0, treq}, 8'h00);
    wr(8'h43, 8'h00);
    wr(8'h42, 8'h01);
    wr(8'h43, 8'h01);
    rd(8'h42, 8'h17);
    wr(8'h42, 8'h01);
    go(2'd0, 1'b1);
    rd(8'h42, 8'h07);
  endtask
  task automatic t_own(logic lb, logic [7:0] exp);
    wr(8'h44, {7'h0, lb});
    wr(8'h42, 8'h01);
    arb <= 1'b1;
    @(posedge ref_clk);
    arb <= 1'b0;
    frame(8'h50, 1'b1);
    done <= 1'b1;
    @(posedge ref_clk);
    done <= 1'b0;
    rd(8'h40, exp);
    wr(8'h40, 8'h01);
    wr(8'h44, 8'h00);
  endtask

  task automatic conclude();
    if (errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Whole run is well under 2000 cycles
  initial begin
    #500000;
    errors++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    t_pins();
    t_rx();
    t_ovr();
    t_local_priority_field();
    t_own(1'b0, 8'h00);
    t_own(1'b1, 8'h01);
    conclude();
  end
endmodule  // tb_top

bind cmb_msg_buf cmb_msg_buf_asserts u_cmb_msg_buf_asserts (
  .ref_clk, .rstn, .reg_wr, .reg_rd, .reg_rdata, .bus_receive_pin,
  .bus_transmit_pin, .eng_rx_bit, .eng_rx_frame_ok, .eng_tx_bit, .eng_tx_req,
  .eng_arb_start, .eng_tx_sel, .eng_tx_active, .eng_tx_byte_index, .eng_tx_byte,
  .eng_tx_done, .eng_tx_fail, .rx_irq, .err_irq, .tx_irq
);

`default_nettype wire
